// ### rtl/powerup_pkg.sv
// Shared constants and types for the power-up sequencer and the main-processor end.
// Assumes a single 100 MHz clock for both ends.
package powerup_pkg;
	// ****************************************
	// Clock and timing
	// ****************************************
	localparam int unsigned CLK_HZ = 100000000;
	localparam int unsigned TICK_PERIOD_US = 16600;
	localparam int unsigned TICK_CYCLES = TICK_PERIOD_US * (CLK_HZ / 1000000);
	localparam int unsigned AUTOBAUD_TIMEOUT_CYCLES = 2000000;
	localparam int unsigned TEST_STEP_CYCLES = 64;
	localparam int unsigned DISK_INIT_CYCLES = 16;
	// ****************************************
	// Baud selections
	// ****************************************
	localparam logic [3:0] BAUD_300 = 4'h1;
	localparam logic [3:0] BAUD_1200 = 4'h3;
	localparam logic [3:0] BAUD_9600 = 4'h6;
	localparam logic [3:0] BAUD_NONE = 4'h0;
	// Bit-time thresholds for the autobaud measurement, in clock cycles
	localparam int unsigned BIT_9600 = 10417;
	localparam int unsigned BIT_1200 = 83333;
	// ****************************************
	// Mode switch and test selection
	// ****************************************
	typedef enum logic [1:0]
	{
		MODE_NORMAL = 2'h0,
		MODE_RESET = 2'h1,
		MODE_TEST = 2'h2
	} mode_sel_t;
	localparam logic [1:0] OPT_LOOPBACK = 2'h1;
	localparam logic [1:0] OPT_DISK_RW = 2'h2;
	// Lamp codes for the test steps
	localparam logic [4:0] LAMP_IO_SELF = 5'h01;
	localparam logic [4:0] LAMP_DISK_NOMEDIA = 5'h02;
	localparam logic [4:0] LAMP_LOOPBACK = 5'h03;
	localparam logic [4:0] LAMP_DISK_RW = 5'h04;
	localparam logic [4:0] LAMP_OFF = 5'h00;
	// ****************************************
	// Main processor boot
	// ****************************************
	localparam logic [15:0] BOOT_ROM_START = 16'o173000;
	localparam logic [15:0] BOOT_ROM_END = 16'o173776;
	localparam logic [1:0] BOOT_DRIVE = 2'h0;
endpackage

// ### rtl/processor_link_if.sv
// Link between the power-up sequencer and the main processor.
// Assumes both ends run on the same clock.
`timescale 1ns/1ps
`default_nettype none
interface processor_link_if;
	logic hold_off;
	logic powerup_ok;
	logic test_mode;
	logic tick_irq;
	logic disk_init;
	logic status_read;
	modport sequencer
	(
		output hold_off,
		output powerup_ok,
		output test_mode,
		output tick_irq,
		output disk_init,
		input status_read
	);
	modport main_cpu
	(
		input hold_off,
		input powerup_ok,
		input test_mode,
		input tick_irq,
		input disk_init,
		output status_read
	);
endinterface
`default_nettype wire

// ### rtl/powerup_sequencer.sv
// Power-up sequencer: configures ports, timer and disk, runs tests, releases main processor.
// Assumes switches and test results are synchronous to ref_clk_in.
`timescale 1ns/1ps
`default_nettype none
module powerup_sequencer
	import powerup_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Switches
	input wire logic [1:0] mode_switch_in,
	input wire logic autobaud_switch_in,
	input wire logic tick_enable_switch_in,
	input wire logic cluster_present_in,
	input wire logic [1:0] test_option_in,
	// Console receive line for autobaud
	input wire logic console_rx_in,
	// Test results
	input wire logic test_done_in,
	input wire logic test_fail_in,
	// Link to main processor
	processor_link_if.sequencer link,
	// Configuration and status
	output logic [3:0] console_baud_out,
	output logic [3:0] modem_baud_out,
	output logic [3:0] printer_baud_out,
	output logic [11:0] cluster_baud_out,
	output logic stack_init_out,
	output logic irq_ctrl_init_out,
	output logic flags_clear_out,
	output logic test_start_out,
	output logic [4:0] cpu_lamps_out,
	output logic [4:0] disk_lamps_out,
	output logic test_failed_out
);
	import powerup_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [8:0]
	{
		S_IDLE = 9'h001,
		S_INIT = 9'h002,
		S_BAUD = 9'h004,
		S_AUTO = 9'h008,
		S_DISK = 9'h010,
		S_TEST = 9'h020,
		S_WAIT = 9'h040,
		S_FAIL = 9'h080,
		S_RUN = 9'h100
	} seq_state_t;

	typedef struct packed
	{
		seq_state_t state;
		logic auto_sw;
		logic tick_sw;
		logic cluster;
		logic test_mode;
		logic [1:0] opt;
		logic [2:0] step;
		logic [31:0] cnt;
		logic [31:0] tick_cnt;
		logic rx_prev;
		logic measuring;
		logic [3:0] con_baud;
		logic [3:0] mdm_baud;
		logic [3:0] prn_baud;
		logic [11:0] clu_baud;
		logic stack_init;
		logic irq_init;
		logic flags_clr;
		logic disk_init;
		logic hold_off;
		logic powerup_ok;
		logic tick_irq;
		logic test_start;
		logic [4:0] lamps;
		logic failed;
	} seq_regs_t;

	seq_regs_t r_q;
	seq_regs_t r_d;

	// Lamp code for a test step
	function automatic logic [4:0] step_lamp(input logic [2:0] s);
		case (s)
			3'h0: step_lamp = LAMP_IO_SELF;
			3'h1: step_lamp = LAMP_DISK_NOMEDIA;
			3'h2: step_lamp = LAMP_LOOPBACK;
			3'h3: step_lamp = LAMP_DISK_RW;
			default: step_lamp = LAMP_OFF;
		endcase
	endfunction

	// Bit time to baud code
	function automatic logic [3:0] measure_baud(input logic [31:0] c);
		if (c <= 32'(BIT_9600))
			measure_baud = BAUD_9600;
		else if (c <= 32'(BIT_1200))
			measure_baud = BAUD_1200;
		else
			measure_baud = BAUD_300;
	endfunction

	// ****************************************
	// Next state
	// ****************************************
	always_comb
	begin
		r_d = r_q;
		r_d.stack_init = 1'b0;
		r_d.irq_init = 1'b0;
		r_d.flags_clr = 1'b0;
		r_d.test_start = 1'b0;
		r_d.rx_prev = console_rx_in;
		// Tick interval timer
		if (r_q.tick_cnt >= 32'(TICK_CYCLES - 1))
			r_d.tick_cnt = '0;
		else
			r_d.tick_cnt = r_q.tick_cnt + 32'h1;
		r_d.tick_irq = r_q.tick_sw && (r_q.state == S_RUN) && (r_q.tick_cnt == 32'(TICK_CYCLES - 1));
		case (r_q.state)
			S_IDLE:
			begin
				r_d.auto_sw = autobaud_switch_in;
				r_d.tick_sw = tick_enable_switch_in;
				r_d.cluster = cluster_present_in;
				r_d.test_mode = (mode_switch_in == MODE_TEST);
				r_d.opt = test_option_in;
				r_d.stack_init = 1'b1;
				r_d.irq_init = 1'b1;
				r_d.flags_clr = 1'b1;
				r_d.tick_cnt = '0;
				r_d.state = S_INIT;
			end
			S_INIT:
			begin
				r_d.mdm_baud = BAUD_1200;
				r_d.prn_baud = BAUD_1200;
				r_d.clu_baud = r_q.cluster ? {3{BAUD_300}} : {3{BAUD_NONE}};
				r_d.state = S_BAUD;
			end
			S_BAUD:
			begin
				r_d.cnt = '0;
				r_d.measuring = 1'b0;
				if (r_q.auto_sw)
					r_d.state = S_AUTO;
				else
				begin
					r_d.con_baud = BAUD_9600;
					r_d.state = S_DISK;
				end
			end
			S_AUTO:
			begin
				// Width of first start bit sets the console rate
				r_d.cnt = r_q.cnt + 32'h1;
				if (!r_q.measuring && r_q.rx_prev && !console_rx_in)
				begin
					r_d.measuring = 1'b1;
					r_d.cnt = '0;
				end
				else if (r_q.measuring && console_rx_in)
				begin
					r_d.con_baud = measure_baud(r_q.cnt);
					r_d.cnt = '0;
					r_d.state = S_DISK;
				end
				else if (!r_q.measuring && r_q.cnt >= 32'(AUTOBAUD_TIMEOUT_CYCLES))
				begin
					r_d.con_baud = BAUD_9600;
					r_d.cnt = '0;
					r_d.state = S_DISK;
				end
			end
			S_DISK:
			begin
				r_d.disk_init = 1'b1;
				r_d.cnt = r_q.cnt + 32'h1;
				if (r_q.cnt >= 32'(DISK_INIT_CYCLES))
				begin
					r_d.disk_init = 1'b0;
					r_d.cnt = '0;
					r_d.step = 3'h0;
					r_d.state = r_q.test_mode ? S_TEST : S_RUN;
				end
			end
			S_TEST:
			begin
				// Skip optional steps the operator did not choose
				if ((r_q.step == 3'h2 && !r_q.opt[0]) || (r_q.step == 3'h3 && !r_q.opt[1]))
					r_d.step = r_q.step + 3'h1;
				else if (r_q.step >= 3'h4)
				begin
					r_d.lamps = LAMP_OFF;
					r_d.state = S_RUN;
				end
				else
				begin
					r_d.lamps = step_lamp(r_q.step);
					r_d.test_start = 1'b1;
					r_d.state = S_WAIT;
				end
			end
			S_WAIT:
			begin
				if (test_done_in)
				begin
					if (test_fail_in)
					begin
						r_d.failed = 1'b1;
						r_d.state = S_FAIL;
					end
					else
					begin
						r_d.step = r_q.step + 3'h1;
						r_d.state = S_TEST;
					end
				end
			end
			S_FAIL:
				r_d.state = S_FAIL;
			S_RUN:
			begin
				r_d.hold_off = 1'b0;
				r_d.powerup_ok = 1'b1;
			end
			default:
				r_d.state = S_IDLE;
		endcase
		// Reset position restarts the whole sequence
		if (mode_switch_in == MODE_RESET)
		begin
			r_d.state = S_IDLE;
			r_d.hold_off = 1'b1;
			r_d.powerup_ok = 1'b0;
			r_d.tick_irq = 1'b0;
			r_d.disk_init = 1'b0;
			r_d.lamps = LAMP_OFF;
			r_d.failed = 1'b0;
		end
	end

	// ****************************************
	// Registers
	// ****************************************
	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			r_q <= '0;
			r_q.state <= S_IDLE;
			r_q.hold_off <= 1'b1;
			r_q.rx_prev <= 1'b1;
		end
		else
			r_q <= r_d;
	end

	// ****************************************
	// Outputs
	// ****************************************
	assign link.hold_off = r_q.hold_off;
	assign link.powerup_ok = r_q.powerup_ok;
	assign link.test_mode = r_q.test_mode;
	assign link.tick_irq = r_q.tick_irq;
	assign link.disk_init = r_q.disk_init;
	assign console_baud_out = r_q.con_baud;
	assign modem_baud_out = r_q.mdm_baud;
	assign printer_baud_out = r_q.prn_baud;
	assign cluster_baud_out = r_q.clu_baud;
	assign stack_init_out = r_q.stack_init;
	assign irq_ctrl_init_out = r_q.irq_init;
	assign flags_clear_out = r_q.flags_clr;
	assign test_start_out = r_q.test_start;
	assign cpu_lamps_out = r_q.lamps;
	assign disk_lamps_out = r_q.lamps;
	assign test_failed_out = r_q.failed;
endmodule
`default_nettype wire

// ### rtl/main_cpu_boot.sv
// Main processor boot end: status read, memory test, error report, disk load.
// Assumes the memory test result arrives as a done/fail pulse pair.
`timescale 1ns/1ps
`default_nettype none
module main_cpu_boot
	import powerup_pkg::*;
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Link to sequencer
	processor_link_if.main_cpu link,
	// Memory test result
	input wire logic mem_test_done_in,
	input wire logic mem_test_fail_in,
	input wire logic [15:0] mem_fail_addr_in,
	// Boot activity
	output logic [15:0] fetch_addr_out,
	output logic mem_test_run_out,
	output logic print_error_out,
	output logic [15:0] error_addr_out,
	output logic disk_load_out,
	output logic [1:0] load_drive_out,
	output logic self_test_seen_out
);
	import powerup_pkg::*;

	// ****************************************
	// State
	// ****************************************
	typedef enum logic [5:0]
	{
		B_HELD = 6'h01,
		B_STATUS = 6'h02,
		B_TEST = 6'h04,
		B_ERROR = 6'h08,
		B_LOAD = 6'h10,
		B_DONE = 6'h20
	} boot_state_t;

	typedef struct packed
	{
		boot_state_t state;
		logic status_rd;
		logic [15:0] fetch;
		logic run;
		logic print;
		logic [15:0] err_addr;
		logic load;
		logic test_seen;
	} boot_regs_t;

	boot_regs_t r_q;
	boot_regs_t r_d;

	always_comb
	begin
		r_d = r_q;
		r_d.status_rd = 1'b0;
		r_d.print = 1'b0;
		r_d.load = 1'b0;
		case (r_q.state)
			B_HELD:
				if (!link.hold_off)
				begin
					r_d.status_rd = 1'b1;
					r_d.state = B_STATUS;
				end
			B_STATUS:
			begin
				r_d.test_seen = link.test_mode;
				if (link.powerup_ok)
				begin
					r_d.fetch = BOOT_ROM_START;
					r_d.run = 1'b1;
					r_d.state = B_TEST;
				end
			end
			B_TEST:
				if (mem_test_done_in)
				begin
					r_d.run = 1'b0;
					if (mem_test_fail_in)
					begin
						r_d.err_addr = mem_fail_addr_in;
						r_d.print = 1'b1;
						r_d.state = B_ERROR;
					end
					else
						r_d.state = B_LOAD;
				end
			B_LOAD:
			begin
				r_d.load = 1'b1;
				r_d.state = B_DONE;
			end
			B_ERROR, B_DONE:
				r_d.state = r_q.state;
			default:
				r_d.state = B_HELD;
		endcase
		if (link.hold_off)
		begin
			r_d.state = B_HELD;
			r_d.run = 1'b0;
		end
	end

	always_ff @(posedge ref_clk_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			r_q <= '0;
			r_q.state <= B_HELD;
		end
		else
			r_q <= r_d;
	end

	assign link.status_read = r_q.status_rd;
	assign fetch_addr_out = r_q.fetch;
	assign mem_test_run_out = r_q.run;
	assign print_error_out = r_q.print;
	assign error_addr_out = r_q.err_addr;
	assign disk_load_out = r_q.load;
	assign load_drive_out = BOOT_DRIVE;
	assign self_test_seen_out = r_q.test_seen;
endmodule
`default_nettype wire

// ### verif/powerup_monitor.sv
// Checker for the link between the sequencer and the main processor end.
// Assumes the bench instantiates it beside the link interface.
`timescale 1ns/1ps
`default_nettype none
module powerup_monitor
(
	// Clock and reset
	input wire logic ref_clk_in,
	input wire logic resetn_in,
	// Link signals
	input wire logic hold_off,
	input wire logic powerup_ok,
	input wire logic test_mode,
	input wire logic tick_irq,
	input wire logic disk_init,
	input wire logic status_read
);
	logic [4:0] init_cnt_q;
	logic [4:0] init_cnt_d;
	always_comb init_cnt_d = disk_init ? init_cnt_q + 5'h01 : 5'h00;
	always_ff @(posedge ref_clk_in or negedge resetn_in)
		if (!resetn_in)
			init_cnt_q <= 5'h00;
		else
			init_cnt_q <= init_cnt_d;
	default clocking @(posedge ref_clk_in); endclocking
	default disable iff (!resetn_in);
	init_len_a: assert property ($fell(disk_init) |-> init_cnt_q == 5'h10)
		else $error("disk init length wrong");
	init_bound_a: assert property (init_cnt_q <= 5'h10)
		else $error("disk init too long");
	held_init_a: assert property (disk_init |-> hold_off)
		else $error("released during disk init");
	release_a: assert property ($fell(hold_off) |-> powerup_ok && !disk_init)
		else $error("bad release");
	exclusive_a: assert property (powerup_ok |-> !hold_off)
		else $error("powerup ok while held");
	stays_up_a: assert property (powerup_ok |=> powerup_ok || hold_off)
		else $error("powerup ok dropped");
	tick_held_a: assert property (tick_irq |-> !hold_off)
		else $error("tick while held");
	tick_pulse_a: assert property (tick_irq |=> !tick_irq)
		else $error("tick not a pulse");
	status_when_a: assert property (status_read |-> powerup_ok)
		else $error("status read before release");
	mode_stable_a: assert property (powerup_ok && $past(powerup_ok) |-> $stable(test_mode))
		else $error("test mode changed");
	cover property ($fell(hold_off) && test_mode);
	cover property ($fell(hold_off) && !test_mode);
	cover property (status_read);
endmodule
`default_nettype wire

// ### verif/tb.sv
// Testbench joining sequencer and main processor end through the link.
// Assumes a 100 MHz clock and the shared power-up package.
`timescale 1ns/1ps
`default_nettype none
module tb;
	import powerup_pkg::*;
	typedef struct {logic ab; logic cl; int low; logic mf; logic [15:0] addr; logic [3:0] con;} row_t;
	row_t rows[4] = '{
		'{1'b0, 1'b0, 0, 1'b0, 16'h0000, BAUD_9600},
		'{1'b0, 1'b1, 0, 1'b1, 16'h0a5c, BAUD_9600},
		'{1'b1, 1'b0, 200, 1'b0, 16'h0000, BAUD_9600},
		'{1'b1, 1'b1, 20000, 1'b1, 16'h1ffe, BAUD_1200}
	};
	logic ref_clk_in = 1'b0;
	logic resetn_in = 1'b0;
	logic [1:0] mode_sw = MODE_NORMAL;
	logic [1:0] opt = 2'h0;
	logic ab_sw = 1'b0, tick_sw = 1'b0, cl_in = 1'b0, rx = 1'b1, t_done = 1'b0, t_fail = 1'b0;
	logic m_done = 1'b0, m_fail = 1'b0;
	logic [15:0] m_addr = 16'h0000;
	logic [3:0] con_b, mod_b, prn_b;
	logic [11:0] cl_b;
	logic stk, irqc, flg, t_start, t_failed, m_run, prt, dload, st_seen;
	logic [4:0] cpu_l, disk_l;
	logic [15:0] fetch, err_addr;
	logic [1:0] drive;
	logic seen_init, seen_prt, seen_load;
	int n_errors = 0;
	int num_checks = 0;
	int cyc = 0;
	processor_link_if link();
	powerup_sequencer i_powerup_sequencer (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.mode_switch_in(mode_sw), .autobaud_switch_in(ab_sw), .tick_enable_switch_in(tick_sw),
		.cluster_present_in(cl_in), .test_option_in(opt), .console_rx_in(rx), .test_done_in(t_done),
		.test_fail_in(t_fail), .link(link), .console_baud_out(con_b), .modem_baud_out(mod_b),
		.printer_baud_out(prn_b), .cluster_baud_out(cl_b), .stack_init_out(stk), .irq_ctrl_init_out(irqc),
		.flags_clear_out(flg), .test_start_out(t_start), .cpu_lamps_out(cpu_l), .disk_lamps_out(disk_l),
		.test_failed_out(t_failed));
	main_cpu_boot i_main_cpu_boot (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in), .link(link),
		.mem_test_done_in(m_done), .mem_test_fail_in(m_fail), .mem_fail_addr_in(m_addr),
		.fetch_addr_out(fetch), .mem_test_run_out(m_run), .print_error_out(prt), .error_addr_out(err_addr),
		.disk_load_out(dload), .load_drive_out(drive), .self_test_seen_out(st_seen));
	powerup_monitor i_powerup_monitor (.ref_clk_in(ref_clk_in), .resetn_in(resetn_in),
		.hold_off(link.hold_off), .powerup_ok(link.powerup_ok), .test_mode(link.test_mode),
		.tick_irq(link.tick_irq), .disk_init(link.disk_init), .status_read(link.status_read));
	always #5 ref_clk_in = ~ref_clk_in;
	always @(posedge ref_clk_in or negedge resetn_in)
		if (!resetn_in)
			{seen_init, seen_prt, seen_load} <= 3'h0;
		else
		begin
			if (stk && irqc && flg)
				seen_init <= 1'b1;
			if (prt)
				seen_prt <= 1'b1;
			if (dload)
				seen_load <= 1'b1;
		end
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
			n_errors++;
		end
	endtask
	task automatic end_sim();
		if (n_errors == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge ref_clk_in)
	begin
		cyc++;
		if (cyc == 100000)
		begin
			n_errors++;
			end_sim();
		end
	end
	task automatic boot();
		resetn_in = 1'b0;
		repeat (4) @(negedge ref_clk_in);
		resetn_in = 1'b1;
	endtask
	task automatic wait_up(input int lim);
		for (int k = 0; k < lim && link.powerup_ok !== 1'b1; k++) @(negedge ref_clk_in);
	endtask
	task automatic run_tests(input logic [1:0] o, input int fail_at);
		mode_sw = MODE_TEST;
		opt = o;
		boot();
		for (int s = 1; s <= 4; s++)
		begin
			if ((s == 3 && !o[0]) || (s == 4 && !o[1]))
				continue;
			for (int k = 0; k < 300 && t_start !== 1'b1; k++) @(negedge ref_clk_in);
			@(negedge ref_clk_in);
			check("cpu lamps", cpu_l, s[15:0]);
			check("disk lamps", disk_l, s[15:0]);
			check("held off", link.hold_off, 1'b1);
			t_done = 1'b1;
			t_fail = (s == fail_at);
			@(negedge ref_clk_in);
			t_done = 1'b0;
			if (s == fail_at)
			begin
				repeat (100) @(negedge ref_clk_in);
				check("lamps held", cpu_l, s[15:0]);
				check("failed", t_failed, 1'b1);
				check("no release", link.hold_off, 1'b1);
				return;
			end
		end
		wait_up(300);
		check("test release", link.powerup_ok, 1'b1);
		check("test mode", link.test_mode, 1'b1);
		repeat (5) @(negedge ref_clk_in);
		check("self test seen", st_seen, 1'b1);
	endtask
	initial
	begin
		foreach (rows[i])
		begin
			ab_sw = rows[i].ab;
			tick_sw = rows[i].ab;
			cl_in = rows[i].cl;
			m_fail = rows[i].mf;
			m_addr = rows[i].addr;
			boot();
			if (rows[i].low > 0)
			begin
				repeat (5) @(negedge ref_clk_in);
				rx = 1'b0;
				repeat (rows[i].low) @(negedge ref_clk_in);
				rx = 1'b1;
			end
			wait_up(30000);
			check("release", link.powerup_ok, 1'b1);
			check("normal mode", link.test_mode, 1'b0);
			check("init pulses", seen_init, 1'b1);
			check("modem baud", mod_b, BAUD_1200);
			check("printer baud", prn_b, BAUD_1200);
			check("cluster baud", cl_b, rows[i].cl ? {3{BAUD_300}} : 12'h000);
			check("console baud", con_b, rows[i].con);
			for (int k = 0; k < 20 && m_run !== 1'b1; k++) @(negedge ref_clk_in);
			check("fetch addr", fetch, BOOT_ROM_START);
			m_done = 1'b1;
			@(negedge ref_clk_in);
			m_done = 1'b0;
			repeat (3) @(negedge ref_clk_in);
			check("print error", seen_prt, rows[i].mf);
			check("disk load", seen_load, !rows[i].mf);
			if (rows[i].mf)
				check("error addr", err_addr, rows[i].addr);
			check("load drive", drive, BOOT_DRIVE);
		end
		ab_sw = 1'b0;
		mode_sw = MODE_RESET;
		repeat (3) @(negedge ref_clk_in);
		check("reset switch hold", link.hold_off, 1'b1);
		mode_sw = MODE_NORMAL;
		wait_up(300);
		check("release again", link.powerup_ok, 1'b1);
		run_tests(OPT_LOOPBACK | OPT_DISK_RW, 0);
		run_tests(2'h0, 2);
		end_sim();
	end
endmodule
`default_nettype wire
